// ### shared/ssiar_pkg.sv
// Constants shared by the serial angle readout block.
package ssiar_pkg;

  localparam int ANGLE_W = 16;
  localparam int FIFO_DEPTH = 16;

  // Configuration register holding the parity sense select bit.
  localparam logic [7:0] PARITY_AND_OUTPUT_CONFIG_ADDR = 8'h1c;
  localparam logic [7:0] PARITY_AND_OUTPUT_CONFIG_RESET = 8'h00;
  localparam int PARITY_SENSE_SELECT_BIT = 4;

  // Frame layout in serial clock counts, the dummy clock being count 1.
  localparam logic [4:0] DUMMY_CLOCKS = 5'h01;
  localparam logic [4:0] FRAME_ANGLE_CLOCKS = 5'h11;
  localparam logic [4:0] FRAME_PARITY_CLOCKS = 5'h12;

  localparam int SYS_CLK_MHZ = 250;

  // Serial clock limits kept by the controller.
  localparam int SERIAL_CLK_MAX_KHZ = 5000;
  localparam int SERIAL_PERIOD_MIN_NS = 200;
  localparam int SERIAL_PERIOD_MAX_NS = 16000;
  localparam int SERIAL_PHASE_MIN_NS = 100;
  localparam int SERIAL_PHASE_MAX_NS = 8000;

  // Least hold timeout; the count rounds up and here comes out exact.
  localparam int HOLD_TIMEOUT_US = 25;
  localparam int HOLD_TIMEOUT_CYCLES = HOLD_TIMEOUT_US * SYS_CLK_MHZ;

  // Least dead time the controller keeps between frames.
  localparam int INTER_FRAME_GAP_US = 40;
  localparam int INTER_FRAME_GAP_CYCLES = INTER_FRAME_GAP_US * SYS_CLK_MHZ;

  // Internal refresh period of the output buffer.
  localparam int REFRESH_PERIOD_NS = 1000;
  localparam int REFRESH_PERIOD_CYCLES = (REFRESH_PERIOD_NS * SYS_CLK_MHZ) / 1000;

  localparam logic IDLE_LEVEL = 1'b1;

endpackage

// ### verilog/ssiar_fifo.sv
// Sample FIFO with a registered read stage in front of its memory.
module ssiar_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [AW-1:0] rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic push, load;

  assign in_ready = count != (AW+1)'(DEPTH);

  always_comb begin
    push = in_valid & in_ready;
    // The read stage refills whenever it is empty or being drained.
    load = (count != '0) & (~out_valid | out_ready);
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = load ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    next_out_valid = load | (out_valid & ~out_ready);
    next_out_data = load ? mem[rd_ptr] : out_data;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

// ### verilog/ssiar_readout.sv
// Serial angle readout: sample buffer, hold timing and the link data driver.
module ssiar_readout #(
  parameter int HOLD_CYCLES = ssiar_pkg::HOLD_TIMEOUT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic serial_angle_clock,
  output logic serial_angle_data,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [15:0] sample_angle,
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wr_data,
  output logic [7:0] cfg_rd_data,
  output logic buffer_held,
  output logic [15:0] buffer_angle
);

  typedef enum logic [0:0] {
    ST_FREE,
    ST_HELD
  } ssiar_state_t;

  // Bit that the link drives for the clock following count n.
  function automatic logic frame_bit(
    input logic [4:0] n,
    input logic [15:0] word,
    input logic parity
  );
    logic b;
    b = ssiar_pkg::IDLE_LEVEL;
    if (n >= ssiar_pkg::DUMMY_CLOCKS && n < ssiar_pkg::FRAME_ANGLE_CLOCKS) begin
      b = word[4'(ssiar_pkg::ANGLE_W - 1) - 4'(n - ssiar_pkg::DUMMY_CLOCKS)];
    end else if (n == ssiar_pkg::FRAME_ANGLE_CLOCKS) begin
      b = parity;
    end
    return b;
  endfunction

  // Configuration register.
  logic [7:0] cfg, next_cfg;
  logic [7:0] next_cfg_rd_data;
  logic cfg_hit;

  always_comb begin
    cfg_hit = cfg_addr == ssiar_pkg::PARITY_AND_OUTPUT_CONFIG_ADDR;
    next_cfg = cfg;
    if (cfg_wr_en && cfg_hit) begin
      next_cfg = cfg_wr_data;
    end
    next_cfg_rd_data = cfg_hit ? cfg : 8'h00;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg <= ssiar_pkg::PARITY_AND_OUTPUT_CONFIG_RESET;
      cfg_rd_data <= 8'h00;
    end else begin
      cfg <= next_cfg;
      cfg_rd_data <= next_cfg_rd_data;
    end
  end

  // Samples queue here so that a long hold does not lose the producer's words.
  logic fifo_valid;
  logic fifo_pop;
  logic [15:0] fifo_data;

  ssiar_fifo #(
    .WIDTH(ssiar_pkg::ANGLE_W),
    .DEPTH(ssiar_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_angle),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // Serial clock seen from the system domain through two flip-flops.
  logic sclk_meta, sclk_sync, sclk_prev;
  logic sclk_fall, sclk_rise;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sclk_meta <= 1'b1;
      sclk_sync <= 1'b1;
      sclk_prev <= 1'b1;
    end else begin
      sclk_meta <= serial_angle_clock;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
    end
  end

  assign sclk_fall = sclk_prev & ~sclk_sync;
  assign sclk_rise = ~sclk_prev & sclk_sync;

  // Refresh timebase.
  logic [15:0] refresh_cnt, next_refresh_cnt;
  logic refresh_tick;

  always_comb begin
    refresh_tick = refresh_cnt == 16'h0000;
    next_refresh_cnt = refresh_tick ? 16'(ssiar_pkg::REFRESH_PERIOD_CYCLES - 1) : refresh_cnt - 16'h0001;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      refresh_cnt <= 16'h0000;
    end else begin
      refresh_cnt <= next_refresh_cnt;
    end
  end

  // Buffer, hold and frame position.
  ssiar_state_t state, next_state;
  logic [15:0] word, next_word;
  logic [4:0] clk_count, next_clk_count;
  logic [15:0] hold_timer, next_hold_timer;
  logic link_bit, next_link_bit;
  logic drive_en, next_drive_en;
  logic parity;

  always_comb begin
    parity = (^word) ^ cfg[ssiar_pkg::PARITY_SENSE_SELECT_BIT];
    fifo_pop = 1'b0;
    next_state = state;
    next_word = word;
    next_clk_count = clk_count;
    next_hold_timer = hold_timer;
    next_link_bit = link_bit;
    next_drive_en = drive_en;
    unique case (state)
      ST_FREE: begin
        if (sclk_fall) begin
          // Freezing at the frame's first edge keeps the word steady before the MSB is driven.
          next_state = ST_HELD;
          next_clk_count = ssiar_pkg::DUMMY_CLOCKS;
          next_hold_timer = 16'(HOLD_CYCLES);
          // The dummy's rising edge already carries the MSB, so it is prepared here.
          next_link_bit = frame_bit(ssiar_pkg::DUMMY_CLOCKS, word, parity);
        end else if (refresh_tick && fifo_valid) begin
          fifo_pop = 1'b1;
          next_word = fifo_data;
        end
      end
      ST_HELD: begin
        if (sclk_rise) begin
          next_drive_en = 1'b1;
        end
        if (sclk_fall) begin
          // Any number of data clocks is fine; the count saturates past the parity.
          if (clk_count != ssiar_pkg::FRAME_PARITY_CLOCKS) begin
            next_clk_count = clk_count + 5'h01;
          end
          next_link_bit = frame_bit(clk_count + 5'h01, word, parity);
          next_hold_timer = 16'(HOLD_CYCLES);
        end else if (hold_timer != 16'h0000) begin
          next_hold_timer = hold_timer - 16'h0001;
        end else if (sclk_sync) begin
          next_state = ST_FREE;
          next_clk_count = 5'h00;
          next_drive_en = 1'b0;
          next_link_bit = ssiar_pkg::IDLE_LEVEL;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_FREE;
      word <= 16'h0000;
      clk_count <= 5'h00;
      hold_timer <= 16'h0000;
      link_bit <= ssiar_pkg::IDLE_LEVEL;
      drive_en <= 1'b0;
    end else begin
      state <= next_state;
      word <= next_word;
      clk_count <= next_clk_count;
      hold_timer <= next_hold_timer;
      link_bit <= next_link_bit;
      drive_en <= next_drive_en;
    end
  end

  assign buffer_held = state == ST_HELD;
  assign buffer_angle = word;

  // Link domain. The bit is updated in the system domain just after a falling
  // edge and is quiet for the rest of the low phase before the rising edge that
  // takes it, so it crosses without a synchroniser. Only angle and parity bits
  // ever travel this way; the link carries no command path.
  logic link_q;
  logic next_link_q;

  always_comb begin
    next_link_q = link_bit;
  end

  always_ff @(posedge serial_angle_clock) begin
    link_q <= next_link_q;
  end

  // The link flop has no reset because its clock may not run; the enable
  // masks it to the idle level until the frame's first rising edge.
  assign serial_angle_data = link_q | ~drive_en;

endmodule

// ### dv/ssiar_ctrl_model.sv
// Link controller model: makes the link clock and samples data on falls.
module ssiar_ctrl_model (
  output logic sck,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial sck = 1'b1;
  // The clock stands high outside frames; a frame may stop early.
  task automatic read_frame(input int n, output logic [16:0] bits);
    bits = 17'h00000;
    // Every frame opens only after a full dead time with the clock high.
    #(ssiar_pkg::INTER_FRAME_GAP_US * 1000);
    #1;
    for (int k = 1; k <= n; k++) begin
      sck = 1'b0;
      if (k > 1) begin
        bits = {bits[15:0], sda};
      end
      // Shortest legal phases give the fastest clock the link allows.
      #(ssiar_pkg::SERIAL_PHASE_MIN_NS) sck = 1'b1;
      #(ssiar_pkg::SERIAL_PHASE_MIN_NS);
    end
  endtask
endmodule

// ### dv/ssiar_readout_monitor.sv
// Port assertions for the serial angle readout.
module ssiar_readout_monitor #(
  parameter int HOLD_CYCLES = 100
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic serial_angle_clock,
  input wire logic serial_angle_data,
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wr_data,
  input wire logic [7:0] cfg_rd_data,
  input wire logic buffer_held,
  input wire logic [15:0] buffer_angle
);
  default clocking mon_cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic sck_q;
  logic [15:0] since_fall;
  logic [15:0] next_since_fall;
  // Counted from the raw fall, so the design's synchroniser only adds margin.
  always_comb begin
    next_since_fall = since_fall;
    if (sck_q && !serial_angle_clock) begin
      next_since_fall = 16'h0000;
    end else if (since_fall != 16'hffff) begin
      next_since_fall = since_fall + 16'h0001;
    end
  end
  always_ff @(posedge clk_sys) begin
    sck_q <= serial_angle_clock;
    since_fall <= reset ? 16'h0000 : next_since_fall;
  end
  a_idle_data_level: assert property (!buffer_held && !$past(buffer_held) |-> serial_angle_data)
    else $error("data not idle");
  a_cfg_unmapped_zero: assert property (cfg_addr != 8'h1c |=> cfg_rd_data == 8'h00)
    else $error("unmapped read");
  a_cfg_write_back: assert property (cfg_wr_en && cfg_addr == 8'h1c ##1 cfg_addr == 8'h1c && !cfg_wr_en
    |=> cfg_rd_data == $past(cfg_wr_data, 2)) else $error("config write lost");
  a_held_word_stable: assert property (buffer_held && $past(buffer_held) |-> $stable(buffer_angle))
    else $error("held word moved");
  a_fall_freezes: assert property ($fell(serial_angle_clock) && !buffer_held |-> ##[1:4] buffer_held)
    else $error("no freeze");
  a_hold_min_time: assert property ($fell(buffer_held) |-> since_fall >= HOLD_CYCLES)
    else $error("early release");
  a_hold_max_time: assert property (since_fall == HOLD_CYCLES + 8 && serial_angle_clock |-> !buffer_held)
    else $error("late release");
  a_data_on_rise: assert property ((buffer_held && !serial_angle_clock)[*4] |-> $stable(serial_angle_data))
    else $error("data moved while low");
endmodule
bind ssiar_readout ssiar_readout_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_mon (
  .clk_sys(clk_sys),
  .reset(reset),
  .serial_angle_clock(serial_angle_clock),
  .serial_angle_data(serial_angle_data),
  .cfg_wr_en(cfg_wr_en),
  .cfg_addr(cfg_addr),
  .cfg_wr_data(cfg_wr_data),
  .cfg_rd_data(cfg_rd_data),
  .buffer_held(buffer_held),
  .buffer_angle(buffer_angle)
);

// ### dv/ssi_angle_readout_bench.sv
// Self-checking bench for the serial angle readout.
`define check_eq(a, b) begin \
  checked++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("BAD %0t got %h want %h", $time, a, b); \
  end \
end
module ssi_angle_readout_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic sck;
  logic sda;
  logic sample_valid = 1'b0;
  logic sample_ready;
  logic [15:0] sample_angle = 16'h0000;
  logic cfg_wr_en = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wr_data = 8'h00;
  logic [7:0] cfg_rd_data;
  logic buffer_held;
  logic [15:0] buffer_angle;
  logic [16:0] bits;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  ssiar_readout #(.HOLD_CYCLES(100)) u_dut (
    .clk_sys(clk_sys),
    .reset(reset),
    .serial_angle_clock(sck),
    .serial_angle_data(sda),
    .sample_valid(sample_valid),
    .sample_ready(sample_ready),
    .sample_angle(sample_angle),
    .cfg_wr_en(cfg_wr_en),
    .cfg_addr(cfg_addr),
    .cfg_wr_data(cfg_wr_data),
    .cfg_rd_data(cfg_rd_data),
    .buffer_held(buffer_held),
    .buffer_angle(buffer_angle)
  );
  ssiar_ctrl_model u_ctrl (
    .sck(sck),
    .sda(sda)
  );
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic finish_test();
    $display("mismatches %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 70000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cfg_addr = a;
    cfg_wr_data = d;
    cfg_wr_en = 1'b1;
    @(negedge clk_sys);
    cfg_wr_en = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic push(input logic [15:0] w, output logic ok);
    @(negedge clk_sys);
    ok = sample_ready;
    sample_valid = ok;
    sample_angle = w;
    @(negedge clk_sys);
    sample_valid = 1'b0;
  endtask
  task automatic regs();
    cfg_addr = 8'h1c;
    repeat (2) @(negedge clk_sys);
    `check_eq(cfg_rd_data, 8'h00)
    cfg_wr(8'h1a, 8'hff);
    `check_eq(cfg_rd_data, 8'h00)
    cfg_wr(8'h1c, 8'hef);
    `check_eq(cfg_rd_data, 8'hef)
  endtask
  task automatic frame(input logic [15:0] w, input int n, input logic odd);
    logic ok;
    logic [16:0] exp;
    push(w, ok);
    repeat (600) @(negedge clk_sys);
    `check_eq(buffer_angle, w)
    exp = {w, odd ? ~^w : ^w} >> (18 - n);
    u_ctrl.read_frame(n, bits);
    `check_eq(bits, exp)
    `check_eq(buffer_held, 1'b1)
    push(~w, ok);
    `check_eq(buffer_angle, w)
    // The gap outlasts the shortened hold timeout.
    repeat (250) @(negedge clk_sys);
    `check_eq(buffer_held, 1'b0)
    `check_eq(sda, 1'b1)
  endtask
  task automatic fill_drain();
    logic ok;
    int n;
    logic [15:0] last;
    n = 0;
    for (int i = 0; i < 24; i++) begin
      push(16'ha000 + 16'(i), ok);
      if (ok) begin
        n++;
        last = 16'ha000 + 16'(i);
      end
    end
    `check_eq(n < 24, 1'b1)
    repeat (7500) @(negedge clk_sys);
    `check_eq(buffer_angle, last)
    `check_eq(sample_ready, 1'b1)
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    reset = 1'b0;
    regs();
    frame(16'h8001, 18, 1'b0);
    cfg_wr(8'h1c, 8'h10);
    frame(16'h3a5c, 18, 1'b1);
    frame(16'hc3f0, 13, 1'b1);
    frame(16'h7ffe, 17, 1'b1);
    fill_drain();
    finish_test();
  end
endmodule
